// ==== rtl/vtms_cmp_if.sv ====
`timescale 1ns/1ns
interface vtms_cmp_if;
  logic [19:0] interval;  // Measured step interval
  logic [19:0] threshold; // Threshold
  logic        small_hys; // Use 1/32
  logic        below;     // Interval below threshold (fast)
  modport user (output interval, threshold, small_hys, input below);
  modport cmp  (input interval, threshold, small_hys, output below);
endinterface

// ==== rtl/vtms_hys_cmp.sv ====
`timescale 1ns/1ns
module vtms_hys_cmp (
  input wire logic  i_clk,    // Clock
  input wire logic  i_rst_n,  // Async reset
  vtms_cmp_if.cmp   port      // Compare group
);
  logic [19:0] hys;
  logic [19:0] on_level;
  // ==========================================================
  // Hysteresis: fast only below threshold less a fraction of it,
  // slow again beyond the threshold itself, so the slower switching
  // point is the programmed value and the faster one lies below it
  always_comb begin
    hys      = port.small_hys ? (port.threshold >> vtms_pkg::HYS_SHIFT_SMALL)
                              : (port.threshold >> vtms_pkg::HYS_SHIFT);
    on_level = port.threshold - hys;  // Cannot wrap, hys never exceeds threshold
  end
  // Decision register; holds between the two compare levels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port.below <= 1'b0;
    end else if (port.interval < on_level) begin
      port.below <= 1'b1;
    end else if (port.interval > port.threshold) begin
      port.below <= 1'b0;
    end
  end
endmodule

// ==== rtl/vtms_pkg.sv ====
package vtms_pkg;
  // ===========================================================
  // Register map
  localparam logic [6:0] ADDR_LOWER_THR  = 7'h14;
  localparam logic [6:0] ADDR_HIGH_THR   = 7'h15;
  localparam logic [6:0] ADDR_DIRECT     = 7'h2d;
  localparam logic [6:0] ADDR_MIN_COMM   = 7'h33;
  localparam logic [6:0] ADDR_MODE_CTRL  = 7'h16;
  localparam logic [6:0] ADDR_STATUS     = 7'h17;
  // ===========================================================
  // Field layout
  localparam int         INTERVAL_W      = 20;
  localparam int         MIN_COMM_W      = 23;
  localparam int         COIL_W          = 9;
  localparam int         COIL_A_LSB      = 0;
  localparam int         COIL_B_LSB      = 16;
  localparam int         HOLD_W          = 5;
  localparam int         STEP_DIV        = 256;
  localparam int         SUPPRESS_STEPS  = 3 * 1024;
  localparam int         HYS_SHIFT       = 4;
  localparam int         HYS_SHIFT_SMALL = 5;
  localparam logic [INTERVAL_W-1:0] INTERVAL_MAX = 20'hfffff;
  // Mode control bits
  localparam int CTL_DIRECT    = 0;
  localparam int CTL_VHIGH_CHM = 1;
  localparam int CTL_VHIGH_FS  = 2;
  localparam int CTL_SMALL_HYS = 3;
  localparam int CTL_REDUCE_EN = 4;
  localparam int CTL_STALL_EN  = 5;
  localparam int CTL_STALL_OUT = 6;
  localparam int CTL_STOP_STALL = 7;
  localparam int CTL_PWM_EN    = 8;
  localparam int CTL_SYNC_EN   = 9;
  localparam int CTL_HOLD_LSB  = 16;
  localparam int CTL_W         = 21;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Velocity band
  typedef enum logic [1:0] {VTMS_SLOW, VTMS_MID, VTMS_HIGH} vtms_band_t;
endpackage

// ==== rtl/vtms_top.sv ====
`timescale 1ns/1ns
// What this block does
// - Between thresholds allow current reduction if configured, keep voltage PWM off.
// - Lower threshold at or above interval enables stall detect, output, stop, if configured.
// - Outside commutation mode stall detect turns off below lower threshold velocity.
// - Crossing the high threshold suppresses stall detect for two to three electrical periods.
// - Interval at or below high threshold: no reduction, normal current, no voltage PWM.
// - Above high threshold with chopper bit, force chopper mode one, fast decay zero.
// - Above high threshold, chopper synchronisation is off.
// - Above high threshold with fullstep bit, fullstep and commutation stall detector.
// - Thresholds are step intervals in clock cycles compared with measured interval.
// - High threshold is unsigned 20-bit write-only.
// - Direct mode takes signed coil currents from direct register, bits 8..0 and 24..16.
// - Direct mode scales coil currents by hold current.
// - Direct mode disables velocity based voltage PWM regulation.
// - Commutation runs only while commutation enable input is high.
// - Minimum commutation velocity is 23-bit write-only.
// - Minimum velocity time base is 2^24 clock cycles.
// - Interval counts clocks between 1/256 microsteps, saturates at all ones.
// - Comparisons use 1/16 hysteresis, 1/32 with small hysteresis flag.

// ==========================================================
// Usage notes
// Register map: 0x14 lower threshold, 0x15 high threshold, 0x2d direct
// coil word, 0x33 minimum velocity, 0x16 mode control, 0x17 status.
// Mode control: b0 direct, b1 high chopper, b2 high fullstep, b3 small
// hysteresis, b4 reduction, b5 stall, b6 stall out, b7 stop on stall,
// b8 voltage PWM, b9 sync, b20..16 hold current scale.
// Status: interval in b19..0, velocity band in b21..20.
// STEP_DIV must be a power of two: the interval is a slice of a wider
// clock counter rather than a divider, which keeps the path short.
// Thresholds and minimum velocity are write only and read as zero,
// so a host must keep its own copy of them.
// Mode outputs are combinational from registers; they settle one clock
// after the write or interval change that moves them.
// Comparators hold between their two levels, so a jittery step clock
// near a threshold does not make the modes chatter.
module vtms_top #(
  parameter int STEP_DIV = vtms_pkg::STEP_DIV  // Microsteps per input step
) (
  input  wire logic        I_CLK_SYS,            // System clock
  input  wire logic        I_RESETN,             // Async reset, low
  input  wire logic        I_STEP,               // Step pulse pin
  input  wire logic        I_COMM_ENABLE,        // Commutation enable pin
  input  wire logic        I_WR,                 // Register write strobe
  input  wire logic        I_RD,                 // Register read strobe
  input  wire logic [6:0]  I_ADDR,               // Register address
  input  wire logic [31:0] I_WDATA,              // Write data
  output logic      [31:0] O_RDATA,              // Read data
  output logic      [19:0] O_STEP_INTERVAL,      // Measured interval
  output logic             O_CHOPPER_MODE,       // Forced chopper mode
  output logic             O_FAST_DECAY_ZERO,    // Fast decay time forced zero
  output logic             O_SYNC_ENABLE,        // Chopper sync allowed
  output logic             O_FULLSTEP,           // Fullstep drive
  output logic             O_PWM_ENABLE,         // Voltage PWM allowed
  output logic             O_PWM_AUTO_REG,       // Velocity based PWM regulation
  output logic             O_REDUCE_ENABLE,      // Current reduction allowed
  output logic             O_STALL_DETECT,       // Stall detection active
  output logic             O_STALL_SEL_COMM,     // Stall from commutation detector
  output logic             O_STALL_OUT_EN,       // Stall output allowed
  output logic             O_STOP_ON_STALL,      // Stop on stall allowed
  output logic             O_COMM_ACTIVE,        // Commutation running
  output logic      [22:0] O_MIN_COMM_VELOCITY,  // Minimum velocity, 2^24 clk base
  output logic             O_DIRECT_MODE,        // Direct coil mode
  output logic      [8:0]  O_COIL_A,             // Signed coil A current
  output logic      [8:0]  O_COIL_B,             // Signed coil B current
  output logic      [4:0]  O_CURRENT_SCALE       // Hold current scale in direct mode
);
  // ==========================================================
  // Registers
  logic [19:0] lower_velocity_threshold;
  logic [19:0] high_velocity_threshold;
  logic [31:0] direct_coil_current;
  logic [22:0] min_commutation_velocity;
  logic [20:0] mode_ctrl;
  logic [1:0]  step_sync;
  logic [1:0]  comm_sync;
  logic        step_prev;
  localparam int count_w = vtms_pkg::INTERVAL_W + $clog2(STEP_DIV);
  logic [count_w-1:0] step_count;
  logic [19:0] measured_step_interval;
  logic [11:0] suppress_count;
  logic        high_prev;
  logic        step_edge;
  logic        comm_en;
  vtms_pkg::vtms_band_t band;
  vtms_cmp_if cmp_low ();
  vtms_cmp_if cmp_high ();

  // ==========================================================
  // Register writes; thresholds and minimum velocity are write only
  // Unmapped addresses are ignored so a stray write cannot disturb
  // the mode outputs
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      lower_velocity_threshold <= 20'h00000;
      high_velocity_threshold  <= 20'h00000;
      direct_coil_current      <= 32'h0000_0000;
      min_commutation_velocity <= 23'h000000;
      mode_ctrl                <= 21'h000000;
    end else if (I_WR) begin
      case (I_ADDR)
        vtms_pkg::ADDR_LOWER_THR: lower_velocity_threshold <= I_WDATA[19:0];
        vtms_pkg::ADDR_HIGH_THR:  high_velocity_threshold  <= I_WDATA[19:0];
        vtms_pkg::ADDR_DIRECT:    direct_coil_current      <= I_WDATA;
        vtms_pkg::ADDR_MIN_COMM:  min_commutation_velocity <= I_WDATA[22:0];
        vtms_pkg::ADDR_MODE_CTRL: mode_ctrl                <= I_WDATA[20:0];
        default: ;
      endcase
    end
  end

  // Read mux; write-only registers and unmapped addresses read zero
  // Read data is registered and holds until the next read strobe,
  // so a slow host may fetch it at leisure
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= vtms_pkg::ZERO_WORD;
    end else if (I_RD) begin
      case (I_ADDR)
        vtms_pkg::ADDR_DIRECT:    O_RDATA <= direct_coil_current;
        vtms_pkg::ADDR_MODE_CTRL: O_RDATA <= {11'h000, mode_ctrl};
        vtms_pkg::ADDR_STATUS:    O_RDATA <= {10'h000, band, measured_step_interval};
        default:                  O_RDATA <= vtms_pkg::ZERO_WORD;
      endcase
    end
  end

  // ==========================================================
  // Pin synchronisers; first stage feeds only the second
  // Step and enable pins come from the host's domain; the price is
  // two clocks of latency before a step edge is seen
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      step_sync <= 2'b00;
      comm_sync <= 2'b00;
      step_prev <= 1'b0;
    end else begin
      step_sync <= {step_sync[0], I_STEP};
      comm_sync <= {comm_sync[0], I_COMM_ENABLE};
      step_prev <= step_sync[1];
    end
  end
  assign step_edge = step_sync[1] & ~step_prev;
  assign comm_en   = comm_sync[1];

  // ==========================================================
  // Interval measurement: clocks between input steps, each worth
  // STEP_DIV microsteps of 1/256, so the count is kept STEP_DIV times
  // finer and its top bits are the interval. Saturates at all ones.
  // The counter starts saturated, so the first step after reset reads
  // as standstill rather than as a short interval crossing every threshold.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      step_count             <= '1;
      measured_step_interval <= vtms_pkg::INTERVAL_MAX;
    end else if (step_edge) begin
      step_count             <= count_w'(1);                                     // Edge clock counts
      measured_step_interval <= step_count[count_w-1 -: vtms_pkg::INTERVAL_W];
    end else if (step_count != '1) begin
      step_count <= step_count + count_w'(1);
    end else begin
      measured_step_interval <= vtms_pkg::INTERVAL_MAX;
    end
  end
  assign O_STEP_INTERVAL = measured_step_interval;

  // ==========================================================
  // Threshold comparisons in clock cycles with hysteresis
  // Both comparators share the hysteresis flag; thresholds are taken
  // as written, with no scaling, so host and block use one time base
  assign cmp_low.interval   = measured_step_interval;
  assign cmp_low.threshold  = lower_velocity_threshold;
  assign cmp_low.small_hys  = mode_ctrl[vtms_pkg::CTL_SMALL_HYS];
  assign cmp_high.interval  = measured_step_interval;
  assign cmp_high.threshold = high_velocity_threshold;
  assign cmp_high.small_hys = mode_ctrl[vtms_pkg::CTL_SMALL_HYS];

  vtms_hys_cmp u_cmp_low (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESETN),
    .port    (cmp_low)
  );
  vtms_hys_cmp u_cmp_high (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RESETN),
    .port    (cmp_high)
  );

  // Velocity band from the two comparisons
  always_comb begin
    if (cmp_high.below) begin
      band = vtms_pkg::VTMS_HIGH;
    end else if (cmp_low.below) begin
      band = vtms_pkg::VTMS_MID;
    end else begin
      band = vtms_pkg::VTMS_SLOW;
    end
  end

  // ==========================================================
  // Stall suppression after each high threshold crossing, counted in
  // microsteps: each input step is worth STEP_DIV of them. Three
  // electrical periods, the upper end of two to three, so the detector
  // has settled in the new mode before it is trusted again.
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      high_prev      <= 1'b0;
      suppress_count <= 12'h000;
    end else begin
      high_prev <= cmp_high.below;
      if (high_prev != cmp_high.below) begin
        suppress_count <= 12'(vtms_pkg::SUPPRESS_STEPS);
      end else if (step_edge && suppress_count > 12'(STEP_DIV)) begin
        suppress_count <= suppress_count - 12'(STEP_DIV);
      end else if (step_edge) begin
        suppress_count <= 12'h000;
      end
    end
  end

  // ==========================================================
  // Mode selection outputs
  // Defaults are the slow band values except O_PWM_ENABLE, which the slow
  // band sets itself; each band only overrides what it forces, so no
  // output is left unassigned on any path
  always_comb begin
    O_CHOPPER_MODE    = 1'b0;
    O_FAST_DECAY_ZERO = 1'b0;
    O_SYNC_ENABLE     = mode_ctrl[vtms_pkg::CTL_SYNC_EN];
    O_FULLSTEP        = 1'b0;
    O_STALL_SEL_COMM  = 1'b0;
    O_PWM_ENABLE      = 1'b0;
    O_REDUCE_ENABLE   = 1'b0;
    case (band)
      vtms_pkg::VTMS_HIGH: begin
        O_REDUCE_ENABLE = 1'b0;
        O_PWM_ENABLE    = 1'b0;
        O_SYNC_ENABLE   = 1'b0;
        if (mode_ctrl[vtms_pkg::CTL_VHIGH_CHM]) begin
          O_CHOPPER_MODE    = 1'b1;
          O_FAST_DECAY_ZERO = 1'b1;
        end
        if (mode_ctrl[vtms_pkg::CTL_VHIGH_FS]) begin
          O_FULLSTEP       = 1'b1;
          O_STALL_SEL_COMM = 1'b1;
        end
      end
      vtms_pkg::VTMS_MID: begin
        O_REDUCE_ENABLE = mode_ctrl[vtms_pkg::CTL_REDUCE_EN];
        O_PWM_ENABLE    = 1'b0;
      end
      vtms_pkg::VTMS_SLOW: begin
        O_PWM_ENABLE = mode_ctrl[vtms_pkg::CTL_PWM_EN];
      end
      default: begin
        O_PWM_ENABLE = 1'b0;
      end
    endcase
  end

  // Stall detection: on below lower threshold interval, held on in
  // commutation mode, masked after high threshold crossings
  // Stall output and stop follow the lower threshold alone; the mask
  // concerns the detector, whose readings are false during a switch
  always_comb begin
    O_STALL_DETECT  = mode_ctrl[vtms_pkg::CTL_STALL_EN] && (cmp_low.below || O_COMM_ACTIVE)
                      && (suppress_count == 12'h000);
    O_STALL_OUT_EN  = mode_ctrl[vtms_pkg::CTL_STALL_OUT] && cmp_low.below;
    O_STOP_ON_STALL = mode_ctrl[vtms_pkg::CTL_STOP_STALL] && cmp_low.below;
  end

  // ==========================================================
  // Commutation and direct coil outputs
  // Minimum velocity is passed on unscaled; its time base of 2^24
  // clocks is applied by the commutation logic downstream, which keeps
  // a wide divider out of this block
  assign O_COMM_ACTIVE       = comm_en;
  assign O_MIN_COMM_VELOCITY = min_commutation_velocity;
  assign O_DIRECT_MODE       = mode_ctrl[vtms_pkg::CTL_DIRECT];
  assign O_PWM_AUTO_REG      = ~mode_ctrl[vtms_pkg::CTL_DIRECT];

  // Coil and scale outputs registered; zero current in normal mode
  // Registering keeps a half written coil word from reaching the bridge
  // and lets the downstream table take over cleanly in normal mode
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_COIL_A        <= 9'h000;
      O_COIL_B        <= 9'h000;
      O_CURRENT_SCALE <= 5'h00;
    end else if (mode_ctrl[vtms_pkg::CTL_DIRECT]) begin
      O_COIL_A        <= direct_coil_current[vtms_pkg::COIL_A_LSB +: vtms_pkg::COIL_W];
      O_COIL_B        <= direct_coil_current[vtms_pkg::COIL_B_LSB +: vtms_pkg::COIL_W];
      O_CURRENT_SCALE <= mode_ctrl[vtms_pkg::CTL_HOLD_LSB +: vtms_pkg::HOLD_W];
    end else begin
      O_COIL_A        <= 9'h000;
      O_COIL_B        <= 9'h000;
      O_CURRENT_SCALE <= 5'h00;
    end
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, step, comm_en = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
  logic [6:0]  addr = 7'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [19:0] intv, period = 20'h10;
  logic        chm, fdz, sync, fs, pwm, areg, red, sdet, ssel, sout, sstop, cact, dmode;
  logic [22:0] vmin;
  logic [8:0]  ca, cb;
  logic [4:0]  hs;
  int          errors = 0, n_tests = 0, cycles = 0;

  vtms_host_step host (.i_clk(clk), .i_run(run), .i_period(period), .o_step(step));
  // Short step division so the interval equals clocks between steps
  vtms_top #(.STEP_DIV(1)) dut (
    .I_CLK_SYS(clk), .I_RESETN(rst_n), .I_STEP(step), .I_COMM_ENABLE(comm_en), .I_WR(wr), .I_RD(rd),
    .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_STEP_INTERVAL(intv), .O_CHOPPER_MODE(chm),
    .O_FAST_DECAY_ZERO(fdz), .O_SYNC_ENABLE(sync), .O_FULLSTEP(fs), .O_PWM_ENABLE(pwm), .O_PWM_AUTO_REG(areg),
    .O_REDUCE_ENABLE(red), .O_STALL_DETECT(sdet), .O_STALL_SEL_COMM(ssel), .O_STALL_OUT_EN(sout),
    .O_STOP_ON_STALL(sstop), .O_COMM_ACTIVE(cact), .O_MIN_COMM_VELOCITY(vmin), .O_DIRECT_MODE(dmode),
    .O_COIL_A(ca), .O_COIL_B(cb), .O_CURRENT_SCALE(hs));

  // ===========================================================
  // Clock and hang guard; whole run is a few thousand cycles
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // ===========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'b1; addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  // Let several steps pass so the interval and bands settle
  task automatic run_at(input logic [19:0] p);
    period = p;
    run = 1'b1;
    repeat (4 * p + 10) @(negedge clk);
  endtask
  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ===========================================================
  // Scenarios
  task automatic t_bands();
    wr_reg(vtms_pkg::ADDR_LOWER_THR, 32'd200);
    wr_reg(vtms_pkg::ADDR_HIGH_THR, 32'd50);
    wr_reg(vtms_pkg::ADDR_MODE_CTRL, 32'h0000_03f6); // All features but direct mode, large hysteresis
    run_at(20'd100);
    chk(32'(intv), 32'd100);
    rd_reg(vtms_pkg::ADDR_STATUS, 32'h0010_0064);
    chk(32'(red), 32'h1);
    chk(32'(pwm), 32'h0);
    chk({29'h0, sdet, sout, sstop}, 32'h7);
    run_at(20'd30);
    chk(32'(sdet), 32'h0);
    chk({30'h0, red, pwm}, 32'h0);
    chk({30'h0, chm, fdz}, 32'h3);
    chk(32'(sync), 32'h0);
    chk({30'h0, fs, ssel}, 32'h3);
    run_at(20'd48);
    chk(32'(fs), 32'h1);
    run_at(20'd52);
    chk(32'(fs), 32'h0);
    chk(32'(sync), 32'h1);
    run_at(20'd47);
    chk(32'(fs), 32'h0);
    wr_reg(vtms_pkg::ADDR_MODE_CTRL, 32'h0000_03fe); // Small hysteresis
    repeat (4) @(negedge clk);
    chk(32'(fs), 32'h1);
    run_at(20'd400);
    chk(32'(sdet), 32'h0);
    chk({30'h0, sout, sstop}, 32'h0);
  endtask
  task automatic t_direct();
    run = 1'b0;
    wr_reg(vtms_pkg::ADDR_DIRECT, 32'h01f0_00ff);
    wr_reg(vtms_pkg::ADDR_MODE_CTRL, 32'h000a_0001);
    repeat (2) @(negedge clk);
    chk({dmode, ca, 7'h0, cb}, {1'b1, 9'h0ff, 7'h0, 9'h1f0});
    chk(32'(hs), 32'h0a);
    chk(32'(areg), 32'h0);
    rd_reg(vtms_pkg::ADDR_DIRECT, 32'h01f0_00ff);
    rd_reg(vtms_pkg::ADDR_MODE_CTRL, 32'h000a_0001);
    rd_reg(vtms_pkg::ADDR_LOWER_THR, 32'h0);
    rd_reg(vtms_pkg::ADDR_HIGH_THR, 32'h0);
    rd_reg(7'h7f, 32'h0);
  endtask
  task automatic t_comm();
    wr_reg(vtms_pkg::ADDR_MIN_COMM, 32'h007f_ffff);
    chk(32'(vmin), 32'h007f_ffff);
    rd_reg(vtms_pkg::ADDR_MIN_COMM, 32'h0);
    comm_en = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(cact), 32'h1);
    comm_en = 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(cact), 32'h0);
  endtask

  // ===========================================================
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(32'(intv), 32'h000f_ffff);
    chk(32'(areg), 32'h1);
    t_bands();
    t_direct();
    t_comm();
    conclude();
  end
endmodule

// ==== sim/vtms_host_step.sv ====
`timescale 1ns/1ns
module vtms_host_step (
  input  wire logic        i_clk,    // Clock
  input  wire logic        i_run,    // Stepping on
  input  wire logic [19:0] i_period, // Clocks per step
  output logic             o_step    // Step pin
);
  logic [19:0] cnt = 20'h0;
  // ===========================================================
  // Square step wave, changes off the sampling edge
  always @(negedge i_clk) begin
    if (!i_run) begin
      cnt <= 20'h0;
      o_step <= 1'b0; // Idle pin low, no steps while host drives coils
    end else begin
      cnt <= (cnt >= i_period - 20'h1) ? 20'h0 : cnt + 20'h1;
      o_step <= (cnt < (i_period >> 1));
    end
  end
endmodule

// ==== sim/vtms_props.sv ====
`timescale 1ns/1ns
module vtms_props #(
  parameter int STEP_DIV = 256  // Microsteps per input step
) (
  input wire logic        I_CLK_SYS,           // Clock
  input wire logic        I_RESETN,            // Async reset, low
  input wire logic        I_COMM_ENABLE,       // Commutation pin
  input wire logic        I_WR,                // Write strobe
  input wire logic        I_RD,                // Read strobe
  input wire logic [6:0]  I_ADDR,              // Address
  input wire logic [31:0] I_WDATA,             // Write data
  input wire logic [31:0] O_RDATA,             // Read data
  input wire logic        O_CHOPPER_MODE,      // Chopper mode
  input wire logic        O_FAST_DECAY_ZERO,   // Fast decay zero
  input wire logic        O_SYNC_ENABLE,       // Sync allowed
  input wire logic        O_FULLSTEP,          // Fullstep
  input wire logic        O_PWM_ENABLE,        // Voltage PWM
  input wire logic        O_PWM_AUTO_REG,      // PWM regulation
  input wire logic        O_REDUCE_ENABLE,     // Reduction
  input wire logic        O_STALL_SEL_COMM,    // Stall source
  input wire logic        O_COMM_ACTIVE,       // Commutation on
  input wire logic [22:0] O_MIN_COMM_VELOCITY, // Minimum velocity
  input wire logic        O_DIRECT_MODE        // Direct mode
);
  // ===========================================================
  // Mode relations, all in the one clock domain
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  AST_REDUCE_NO_PWM: assert property (O_REDUCE_ENABLE |-> !O_PWM_ENABLE) else $error("pwm with reduction");
  AST_FS_HIGH_BAND: assert property (O_FULLSTEP |-> !O_PWM_ENABLE && !O_REDUCE_ENABLE) else $error("fullstep band");
  AST_CHM_FORCED: assert property (O_CHOPPER_MODE |-> O_FAST_DECAY_ZERO && !O_SYNC_ENABLE) else $error("chm");
  AST_CHM_NO_PWM: assert property (O_CHOPPER_MODE |-> !O_PWM_ENABLE) else $error("chm with pwm");
  AST_FS_STALL_SEL: assert property (O_FULLSTEP |-> O_STALL_SEL_COMM) else $error("stall source");
  AST_AUTO_REG: assert property (O_PWM_AUTO_REG != O_DIRECT_MODE) else $error("auto regulation");
  // Two synchroniser stages between pin and output
  AST_COMM_SYNC: assert property (O_COMM_ACTIVE == $past(I_COMM_ENABLE, 2)) else $error("comm enable");
  AST_MIN_VEL: assert property (I_WR && I_ADDR == 7'h33 |=>
    O_MIN_COMM_VELOCITY == $past(I_WDATA[22:0])) else $error("min velocity");
  AST_HIGH_WO: assert property (I_RD && I_ADDR == 7'h15 |=> O_RDATA == 32'h0000_0000) else $error("high thr read");
endmodule

bind vtms_top vtms_props #(.STEP_DIV(STEP_DIV)) u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_COMM_ENABLE(I_COMM_ENABLE), .I_WR(I_WR), .I_RD(I_RD),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA), .O_CHOPPER_MODE(O_CHOPPER_MODE),
  .O_FAST_DECAY_ZERO(O_FAST_DECAY_ZERO), .O_SYNC_ENABLE(O_SYNC_ENABLE), .O_FULLSTEP(O_FULLSTEP),
  .O_PWM_ENABLE(O_PWM_ENABLE), .O_PWM_AUTO_REG(O_PWM_AUTO_REG), .O_REDUCE_ENABLE(O_REDUCE_ENABLE),
  .O_STALL_SEL_COMM(O_STALL_SEL_COMM), .O_COMM_ACTIVE(O_COMM_ACTIVE),
  .O_MIN_COMM_VELOCITY(O_MIN_COMM_VELOCITY), .O_DIRECT_MODE(O_DIRECT_MODE));
